// *** inc/hvsp_map.svh ***
// register offsets, field positions and timing counts of the programming-port controller
`ifndef HVSP_MAP_SVH
`define HVSP_MAP_SVH

// ====================================================================
// register offsets
`define HVSP_CTRL_OFS 12'h000
`define HVSP_FRAME_OFS 12'h004
`define HVSP_STATUS_OFS 12'h008
`define HVSP_RXDATA_OFS 12'h00C

// ====================================================================
// field positions
`define HVSP_CTRL_ENTER_BIT 0
`define HVSP_CTRL_EXIT_BIT 1
`define HVSP_FRAME_DATA_LSB 0
`define HVSP_FRAME_INSTR_LSB 8
`define HVSP_FRAME_WAIT_BIT 16
`define HVSP_STAT_BUSY_BIT 0
`define HVSP_STAT_ACTIVE_BIT 1
`define HVSP_STAT_SDO_BIT 2

// ====================================================================
// reset values
`define HVSP_RESET_WORD 32'h0000_0000

// ====================================================================
// timing
`define HVSP_SYS_CLK_NS 10
`define HVSP_SCI_PERIOD_NS 220
`define HVSP_SCI_HALF_CYC ((`HVSP_SCI_PERIOD_NS + 2 * `HVSP_SYS_CLK_NS - 1) / (2 * `HVSP_SYS_CLK_NS))
`define HVSP_ENTRY_TOGGLES 6
`define HVSP_PE_SETUP_NS 100
`define HVSP_PE_SETUP_CYC ((`HVSP_PE_SETUP_NS + `HVSP_SYS_CLK_NS - 1) / `HVSP_SYS_CLK_NS)
`define HVSP_PE_HOLD_NS 100
`define HVSP_PE_HOLD_CYC ((`HVSP_PE_HOLD_NS + `HVSP_SYS_CLK_NS - 1) / `HVSP_SYS_CLK_NS)
`define HVSP_ENTRY_WAIT_US 50
`define HVSP_ENTRY_WAIT_CYC ((`HVSP_ENTRY_WAIT_US * 1000 + `HVSP_SYS_CLK_NS - 1) / `HVSP_SYS_CLK_NS)
`define HVSP_FRAME_BITS 11

`endif

// *** inc/hvsp_pkg.sv ***
// types of the programming-port controller
package hvsp_pkg;

    // one frame as software orders it
    typedef struct packed {
        logic wait_high;
        logic [7:0] instr;
        logic [7:0] data;
    } hvsp_frame_t;

    // pins toward the target device
    typedef struct packed {
        logic serial_clock_in;
        logic serial_data_in;
        logic serial_instr_in;
        logic hv_on;
        logic rst_low;
        logic [2:0] pe;
        logic [2:0] pe_oe;
    } hvsp_pins_t;

    typedef enum logic [3:0] {
        ST_OFF,
        ST_TOGGLE,
        ST_SETUP,
        ST_HOLD,
        ST_SETTLE,
        ST_READY,
        ST_SHIFT_LO,
        ST_SHIFT_HI,
        ST_WAIT_SDO
    } hvsp_state_t;

endpackage

// *** design/hvsp_ctrl.sv ***
// high-voltage serial programming controller with an AHB-Lite register slave
//
// What this block does; address, erase and payload rules are left to software
// - serial clock period kept at least 220ns
// - reset low, six serial clock pulses first
// - entry pins 000, wait 100ns, then HV
// - HV on, entry pins held 100ns
// - release entry pin 2 after hold time
// - wait 50us before first frame
// - reload high address only per window
// - may skip 0xFF writes after erase
// - erase before reprogramming memories
// - erase waits for data output high
// - flash page program waits output high
// - data moves on serial clock falling edge
// - EEPROM page program waits output high
// - frames are 0, eight bits, 00
// - flash write select uses fixed payloads
`timescale 1ns/100ps

`include "hvsp_map.svh"

module hvsp_ctrl #(
    parameter int ENTRY_WAIT_CYC = `HVSP_ENTRY_WAIT_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // target device pins
    output hvsp_pkg::hvsp_pins_t pins,
    input wire logic sdo_in
);
    import hvsp_pkg::*;

    localparam logic [15:0] HALF_CYC = 16'(`HVSP_SCI_HALF_CYC);
    localparam logic [15:0] SETUP_CYC = 16'(`HVSP_PE_SETUP_CYC);
    localparam logic [15:0] HOLD_CYC = 16'(`HVSP_PE_HOLD_CYC);
    localparam logic [15:0] WAIT_CYC = 16'(ENTRY_WAIT_CYC);
    localparam logic [4:0] TOGGLE_HALVES = 5'(2 * `HVSP_ENTRY_TOGGLES);
    localparam logic [3:0] FRAME_BITS = 4'(`HVSP_FRAME_BITS);

    // ====================================================================
    // state
    hvsp_state_t state;
    hvsp_frame_t frame;
    logic frame_go;
    logic enter_req;
    logic exit_req;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [15:0] timer;
    logic [4:0] halves;
    logic [3:0] bit_cnt;
    logic [10:0] tx_data;
    logic [10:0] tx_instr;
    logic [10:0] rx_word;
    logic sdo_meta;
    logic sdo_sync;
    logic busy;
    logic active;

    // an accepted frame counts as busy before the shifter leaves READY
    assign busy = frame_go || ((state != ST_READY) && (state != ST_OFF));
    assign active = (state != ST_OFF) && (state != ST_TOGGLE) && (state != ST_SETUP);

    // ====================================================================
    // data output synchroniser
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sdo_meta <= 1'b0;
            sdo_sync <= 1'b0;
        end else begin
            sdo_meta <= sdo_in;
            sdo_sync <= sdo_meta;
        end
    end

    // ====================================================================
    // ahb-lite slave, zero wait states
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= `HVSP_RESET_WORD;
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= 1'b0;
            if (hsel && htrans[1] && hready) begin
                wr_pend <= hwrite;
                wr_addr <= haddr[11:0];
                hrdata <= `HVSP_RESET_WORD;
                if (!hwrite) begin
                    if (haddr[11:0] == `HVSP_FRAME_OFS) begin
                        hrdata <= {15'h0000, frame};
                    end else if (haddr[11:0] == `HVSP_STATUS_OFS) begin
                        hrdata[`HVSP_STAT_BUSY_BIT] <= busy;
                        hrdata[`HVSP_STAT_ACTIVE_BIT] <= active;
                        hrdata[`HVSP_STAT_SDO_BIT] <= sdo_sync;
                    end else if (haddr[11:0] == `HVSP_RXDATA_OFS) begin
                        hrdata <= {21'h000000, rx_word};
                    end
                end
            end
        end
    end

    // ====================================================================
    // command registers; software orders frames and memory sequencing
    // frame order from software
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            frame <= '0;
            frame_go <= 1'b0;
            enter_req <= 1'b0;
            exit_req <= 1'b0;
        end else begin
            frame_go <= 1'b0;
            enter_req <= 1'b0;
            exit_req <= 1'b0;
            if (wr_pend) begin
                if (wr_addr == `HVSP_CTRL_OFS) begin
                    enter_req <= hwdata[`HVSP_CTRL_ENTER_BIT];
                    exit_req <= hwdata[`HVSP_CTRL_EXIT_BIT];
                end else if (wr_addr == `HVSP_FRAME_OFS && state == ST_READY) begin
                    frame.data <= hwdata[`HVSP_FRAME_DATA_LSB +: 8];
                    frame.instr <= hwdata[`HVSP_FRAME_INSTR_LSB +: 8];
                    frame.wait_high <= hwdata[`HVSP_FRAME_WAIT_BIT];
                    frame_go <= 1'b1;
                end
            end
        end
    end

    // ====================================================================
    // entry sequencer and frame shifter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_OFF;
            pins <= '0;
            timer <= 16'h0000;
            halves <= 5'h00;
            bit_cnt <= 4'h0;
            tx_data <= 11'h000;
            tx_instr <= 11'h000;
            rx_word <= 11'h000;
        end else begin
            if (timer != 16'h0000) begin
                timer <= timer - 16'h0001;
            end
            case (state)
                ST_OFF: begin
                    if (enter_req) begin
                        pins.rst_low <= 1'b1;
                        pins.serial_clock_in <= 1'b0;
                        halves <= 5'h00;
                        timer <= HALF_CYC - 16'h0001;
                        state <= ST_TOGGLE;
                    end
                end
                ST_TOGGLE: begin
                    if (timer == 16'h0000) begin
                        pins.serial_clock_in <= ~pins.serial_clock_in;
                        halves <= halves + 5'h01;
                        timer <= HALF_CYC - 16'h0001;
                        if (halves == TOGGLE_HALVES - 5'h01) begin
                            // entry pattern 000 and setup wait
                            pins.pe <= 3'b000;
                            pins.pe_oe <= 3'b111;
                            timer <= SETUP_CYC - 16'h0001;
                            state <= ST_SETUP;
                        end
                    end
                end
                ST_SETUP: begin
                    if (timer == 16'h0000) begin
                        pins.hv_on <= 1'b1;
                        timer <= HOLD_CYC - 16'h0001;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (timer == 16'h0000) begin
                        pins.pe_oe <= 3'b000;
                        timer <= WAIT_CYC - 16'h0001;
                        state <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (timer == 16'h0000) begin
                        state <= ST_READY;
                    end
                end
                ST_READY: begin
                    if (exit_req) begin
                        pins <= '0;
                        state <= ST_OFF;
                    end else if (frame_go) begin
                        tx_data <= {1'b0, frame.data, 2'b00};
                        tx_instr <= {1'b0, frame.instr, 2'b00};
                        pins.serial_data_in <= 1'b0;
                        pins.serial_instr_in <= 1'b0;
                        bit_cnt <= FRAME_BITS;
                        timer <= HALF_CYC - 16'h0001;
                        state <= ST_SHIFT_LO;
                    end
                end
                ST_SHIFT_LO: begin
                    if (timer == 16'h0000) begin
                        pins.serial_clock_in <= 1'b1;
                        timer <= HALF_CYC - 16'h0001;
                        state <= ST_SHIFT_HI;
                    end
                end
                ST_SHIFT_HI: begin
                    if (timer == 16'h0000) begin
                        pins.serial_clock_in <= 1'b0;
                        rx_word <= {rx_word[9:0], sdo_sync};
                        tx_data <= {tx_data[9:0], 1'b0};
                        tx_instr <= {tx_instr[9:0], 1'b0};
                        pins.serial_data_in <= tx_data[9];
                        pins.serial_instr_in <= tx_instr[9];
                        bit_cnt <= bit_cnt - 4'h1;
                        timer <= HALF_CYC - 16'h0001;
                        if (bit_cnt == 4'h1) begin
                            pins.serial_data_in <= 1'b0;
                            pins.serial_instr_in <= 1'b0;
                            state <= frame.wait_high ? ST_WAIT_SDO : ST_READY;
                        end else begin
                            state <= ST_SHIFT_LO;
                        end
                    end
                end
                ST_WAIT_SDO: begin
                    if (sdo_sync) begin
                        state <= ST_READY;
                    end
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end

endmodule

// *** test/hvsp_props.sv ***
// pin-timing checker of the programming-port controller
`timescale 1ns/100ps
module hvsp_props
import hvsp_pkg::*;
#(parameter int ENTRY_WAIT_CYC = 5000) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // device side
    input wire hvsp_pkg::hvsp_pins_t pins,
    input wire logic sdo_in
);
    // ====================================================================
    // helper counters
    logic [3:0] run;
    logic [3:0] pulses;
    logic [31:0] on_cnt;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            run <= 4'hF;
        end else if ($changed(pins.serial_clock_in)) begin
            run <= 4'h0;
        end else if (run != 4'hF) begin
            run <= run + 4'h1;
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pulses <= 4'h0;
        end else if (!pins.rst_low) begin
            pulses <= 4'h0;
        end else if ($rose(pins.serial_clock_in) && !pins.hv_on && pulses != 4'hF) begin
            pulses <= pulses + 4'h1;
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            on_cnt <= 32'h0;
        end else if (!pins.hv_on) begin
            on_cnt <= 32'h0;
        end else begin
            on_cnt <= on_cnt + 32'h1;
        end
    end
    // ====================================================================
    // assertions
    a_sci_half: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $changed(pins.serial_clock_in) |-> run >= 4'd10) else $error("serial clock half period too short");
    a_six_pulses: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(pins.hv_on) |-> pulses >= 4'd6) else $error("fewer than six clock pulses");
    a_entry_pattern: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(pins.hv_on) |-> pins.rst_low && pins.pe == 3'b000 && $past(pins.pe_oe, 10) == 3'b111)
        else $error("entry pattern not set up before high voltage");
    a_pe_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(pins.hv_on) |-> (pins.pe_oe == 3'b111 && pins.pe == 3'b000)[*8] ##1
        (pins.pe_oe == 3'b111)[*2]) else $error("entry pins not held");
    a_release_pe: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(pins.hv_on) |-> ##[10:12] !pins.pe_oe[2]) else $error("shared pin not released");
    a_settle_wait: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pins.hv_on && $rose(pins.serial_clock_in) |-> on_cnt >= ENTRY_WAIT_CYC + 10)
        else $error("frame before settle time");
    a_data_edge: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $changed({pins.serial_data_in, pins.serial_instr_in}) |-> !pins.serial_clock_in) else $error("data moved while clock high");
    a_data_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(pins.serial_clock_in) |-> $stable({pins.serial_data_in, pins.serial_instr_in})) else $error("data moved at rising edge");
endmodule

bind hvsp_ctrl hvsp_props #(.ENTRY_WAIT_CYC(ENTRY_WAIT_CYC)) hvsp_props_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins), .sdo_in(sdo_in));

// *** test/hvsp_dev_model.sv ***
// behavioural target device behind the programming port
`timescale 1ns/100ps
module hvsp_dev_model
import hvsp_pkg::*;
#(parameter int BUSY_CYC = 40) (
    // clock
    input wire logic sys_clk,
    // pins from the controller
    input wire hvsp_pkg::hvsp_pins_t pins,
    // resolved shared data line
    output logic dout_wire,
    // last frame seen on the serial inputs
    output logic [10:0] last_sdi,
    output logic [10:0] last_sii
);
    logic [10:0] wdi, wii, sh_di, sh_ii, out_frame;
    logic [7:0] cmd, adr;
    logic [3:0] nbit;
    logic prev_sci, on, dbit, last;
    int busy;
    assign wdi = {sh_di[9:0], pins.serial_data_in};
    assign wii = {sh_ii[9:0], pins.serial_instr_in};
    assign out_frame = {1'b0, cmd ^ adr, 2'b00};
    assign dout_wire = pins.pe_oe[2] ? pins.pe[2] : (on ? (busy != 0 ? 1'b0 : dbit) : ~last);
    initial begin
        {sh_di, sh_ii, last_sdi, last_sii, cmd, adr, nbit, prev_sci, on, last} = '0;
        dbit = 1'b1;
        busy = 0;
    end
    always @(posedge sys_clk) begin
        prev_sci <= pins.serial_clock_in;
        last <= dout_wire;
        on <= pins.hv_on;
        if (busy != 0) begin
            busy <= busy - 1;
        end
        if (!pins.hv_on) begin
            nbit <= 4'h0;
        end else if (pins.serial_clock_in && !prev_sci) begin
            sh_di <= wdi;
            sh_ii <= wii;
            dbit <= out_frame[4'd10 - nbit];
            nbit <= (nbit == 4'd10) ? 4'h0 : nbit + 4'h1;
            if (nbit == 4'd10) begin
                last_sdi <= wdi;
                last_sii <= wii;
                if (wii[9:2] == 8'h4C) cmd <= wdi[9:2];
                if (wii[9:2] == 8'h0C) adr <= wdi[9:2];
                if (wii[9:2] == 8'h6C) begin
                    busy <= BUSY_CYC;
                    dbit <= 1'b1;
                end
            end
        end
    end
endmodule

// *** test/hvsp_ctrl_tb.sv ***
// self-checking bench of the programming-port controller
`timescale 1ns/100ps
`include "hvsp_map.svh"
module hvsp_ctrl_tb;
import hvsp_pkg::*;
logic sys_clk, arst_n, hsel, hwrite, hreadyout, hresp, sdo_in;
logic [1:0] htrans;
logic [2:0] hsize;
logic [31:0] haddr, hwdata, hrdata, rd;
logic [10:0] last_sdi, last_sii;
logic [7:0] c, a;
hvsp_pins_t pins;
int n_fail, comparisons, seed, i, t0;
hvsp_ctrl #(.ENTRY_WAIT_CYC(20)) hvsp_ctrl_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pins(pins), .sdo_in(sdo_in));
hvsp_dev_model hvsp_dev_model_inst (.sys_clk(sys_clk), .pins(pins), .dout_wire(sdo_in),
    .last_sdi(last_sdi), .last_sii(last_sii));
initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
end
// ====================================================================
// tasks
task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
        n_fail++;
        $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
endtask
task automatic end_sim();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
task automatic ahb(input logic wr, input logic [11:0] ofs, input logic [31:0] wd);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, ofs};
    hwrite <= wr;
    do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 100);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 100);
    rd = hrdata;
    if (k >= 100) begin n_fail++; end_sim(); end
endtask
task automatic poll(input int bit_no, input logic val);
    int k;
    k = 0;
    do begin ahb(1'b0, `HVSP_STATUS_OFS, 32'h0); k++; end while (rd[bit_no] !== val && k < 2000);
    if (k >= 2000) begin n_fail++; end_sim(); end
endtask
task automatic frame(input logic [7:0] d, input logic [7:0] ii, input logic w);
    ahb(1'b1, `HVSP_FRAME_OFS, {15'h0, w, ii, d});
    poll(`HVSP_STAT_BUSY_BIT, 1'b0);
    check({21'h0, last_sdi}, {21'h0, 1'b0, d, 2'b00}, "data frame");
    check({21'h0, last_sii}, {21'h0, 1'b0, ii, 2'b00}, "instr frame");
endtask
function automatic logic [7:0] exp_byte(input logic [7:0] cm, input logic [7:0] ad);
    return cm ^ ad;
endfunction
initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    end_sim();
end
// ====================================================================
// main sequence
initial begin
    seed = 63;
    {n_fail, comparisons} = '0;
    {arst_n, hsel, htrans, haddr, hwrite, hsize, hwdata} = '0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    hsize <= 3'b010;
    @(posedge sys_clk);
    check({21'h0, pins}, 32'h0, "pins after reset");
    ahb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0, "unmapped read");
    ahb(1'b1, `HVSP_FRAME_OFS, 32'h0000_4C80);
    ahb(1'b0, `HVSP_STATUS_OFS, 32'h0);
    check({30'h0, rd[1:0]}, 32'h0, "status before entry");
    $display("test reset done");
    ahb(1'b1, `HVSP_CTRL_OFS, 32'h1);
    poll(`HVSP_STAT_ACTIVE_BIT, 1'b1);
    poll(`HVSP_STAT_BUSY_BIT, 1'b0);
    check({29'h0, pins.hv_on, pins.rst_low, pins.pe_oe[2]}, 32'h6, "pins after entry");
    $display("test entry done");
    for (i = 0; i < 4; i++) begin
        c = 8'($random(seed));
        a = 8'($random(seed));
        frame(c, 8'h4C, 1'b0);
        frame(a, 8'h0C, 1'b0);
        repeat (2) begin
            frame(8'h00, 8'h7C, 1'b0);
            ahb(1'b0, `HVSP_RXDATA_OFS, 32'h0);
            check({24'h0, rd[9:2]}, {24'h0, exp_byte(c, a)}, "read byte");
        end
    end
    $display("test reads done");
    // erase, then flash select and one page program with the wait bit
    frame(8'h80, 8'h4C, 1'b0);
    frame(8'h00, 8'h64, 1'b0);
    t0 = $time;
    frame(8'h00, 8'h6C, 1'b1);
    // last rising edge plus the model's 40-cycle busy time
    check({31'h0, ($time - t0) / 10 >= (2 * `HVSP_FRAME_BITS - 1) * `HVSP_SCI_HALF_CYC + 40},
        32'h1, "erase wait");
    check({31'h0, rd[`HVSP_STAT_SDO_BIT]}, 32'h1, "output high after erase");
    frame(8'h10, 8'h4C, 1'b0);
    t0 = $time;
    frame(8'h00, 8'h6C, 1'b1);
    check({31'h0, ($time - t0) / 10 >= (2 * `HVSP_FRAME_BITS - 1) * `HVSP_SCI_HALF_CYC + 40},
        32'h1, "page wait");
    $display("test program done");
    ahb(1'b1, `HVSP_CTRL_OFS, 32'h2);
    repeat (4) @(posedge sys_clk);
    check({21'h0, pins}, 32'h0, "pins after exit");
    ahb(1'b0, `HVSP_STATUS_OFS, 32'h0);
    check({30'h0, rd[1:0]}, 32'h0, "status after exit");
    $display("test exit done");
    end_sim();
end
endmodule
